// ==== rtl/timer_pkg.sv ====
// Shared constants for the dual 8-bit timer/counter: register map, fields, codes.
// Assumes an 8-bit register port and a 100 MHz system clock that also serves as fc.
package timer_pkg;
  localparam int unsigned UNITS = 2;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PRESC_W = 11;
  localparam int unsigned FS_DIV_W = 3;
  localparam int unsigned SYS_CLK_MHZ = 100;

  localparam logic [7:0] OFF_CTRL3 = 8'h00;
  localparam logic [7:0] OFF_CMP3 = 8'h04;
  localparam logic [7:0] OFF_COUNT3 = 8'h1C;
  localparam logic [7:0] UNIT_STRIDE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_START_BIT = 3;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CTRL_PRESET_BIT = 7;
  localparam int unsigned CFG_LOW_SPEED_BIT = 0;
  localparam int unsigned CFG_TAP_BIT = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] CFG_RST = 2'h0;

  // Tap exponents of the internal clock choices
  localparam int unsigned EXP_SLOW = 11;
  localparam int unsigned EXP_128 = 7;
  localparam int unsigned EXP_32 = 5;
  localparam int unsigned EXP_8 = 3;
  localparam int unsigned EXP_2 = 1;

  typedef enum logic [2:0] {
    MODE_TIMER_EVENT = 3'b000,
    MODE_DIVIDER = 3'b001,
    MODE_PWM = 3'b010,
    MODE_RESERVED = 3'b011,
    MODE_CASC_TIMER = 3'b100,
    MODE_WARMUP = 3'b101,
    MODE_CASC_PWM = 3'b110,
    MODE_CASC_PPG = 3'b111
  } mode_e;

  typedef enum logic [2:0] {
    SEL_SLOW_TAP = 3'b000,
    SEL_FC_DIV128 = 3'b001,
    SEL_FC_DIV32 = 3'b010,
    SEL_FC_DIV8 = 3'b011,
    SEL_FS = 3'b100,
    SEL_FC_DIV2 = 3'b101,
    SEL_FC = 3'b110,
    SEL_PIN = 3'b111
  } clk_sel_e;
endpackage

// ==== rtl/tick_if.sv ====
// Bundle of source-clock tick pulses, one per clock-select code.
// Driven by the prescaler, read by the counter logic on the same clock.
`timescale 1ns/100ps
interface tick_if;
  logic [7:0] tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ==== rtl/sync_bits.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes the reset given is already synchronous to i_sys_clk on release.
`timescale 1ns/100ps
module sync_bits #(
  parameter int unsigned W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s q, d;

  if (W < 1) begin : g_chk
    $error("sync_bits needs W >= 1");
  end

  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule

// ==== rtl/prescaler.sv ====
// Divider chain producing one-cycle tick pulses for each internal clock-select code, only the fs-derived ones in low speed; the pin code's tick stays low.
// Assumes fc is the system clock and fs arrives already synchronised.
`timescale 1ns/100ps
module prescaler (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_fs_level,
  input wire logic i_tap_sel,
  input wire logic i_low_speed,
  tick_if.src ticks
);
  typedef struct packed {
    logic [timer_pkg::PRESC_W-1:0] fc_cnt;
    logic [timer_pkg::FS_DIV_W-1:0] fs_cnt;
    logic fs_last;
  } presc_s;
  presc_s q, d;
  logic fs_edge;
  logic fs_div8;

  function automatic logic fc_tap(input logic [timer_pkg::PRESC_W-1:0] c, input int unsigned e);
    logic r;
    r = 1'b1;
    for (int i = 0; i < timer_pkg::PRESC_W; i++) begin
      if (i < e && !c[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  assign fs_edge = i_fs_level & ~q.fs_last;
  assign fs_div8 = fs_edge & (&q.fs_cnt);

  always_comb begin
    d = q;
    d.fc_cnt = q.fc_cnt + timer_pkg::PRESC_W'(1);
    d.fs_last = i_fs_level;
    if (fs_edge) begin
      d.fs_cnt = q.fs_cnt + timer_pkg::FS_DIV_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Low-speed operation leaves only fs-derived ticks
  always_comb begin
    ticks.tick = '0;
    ticks.tick[timer_pkg::SEL_SLOW_TAP] = (i_low_speed || i_tap_sel) ? fs_div8
                                          : fc_tap(q.fc_cnt, timer_pkg::EXP_SLOW);
    ticks.tick[timer_pkg::SEL_FC_DIV128] = !i_low_speed && fc_tap(q.fc_cnt, timer_pkg::EXP_128);
    ticks.tick[timer_pkg::SEL_FC_DIV32] = !i_low_speed && fc_tap(q.fc_cnt, timer_pkg::EXP_32);
    ticks.tick[timer_pkg::SEL_FC_DIV8] = !i_low_speed && fc_tap(q.fc_cnt, timer_pkg::EXP_8);
    ticks.tick[timer_pkg::SEL_FS] = fs_edge;
    ticks.tick[timer_pkg::SEL_FC_DIV2] = !i_low_speed && fc_tap(q.fc_cnt, timer_pkg::EXP_2);
    ticks.tick[timer_pkg::SEL_FC] = !i_low_speed;
  end

  property p_low_speed_taps;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_low_speed |-> (ticks.tick[3:1] == 3'h0) && !ticks.tick[6] && !ticks.tick[5];
  endproperty
  a_low_speed_taps: assert property (p_low_speed_taps)
    else $error("fast tap active in low-speed mode");
endmodule

// ==== rtl/dual_timer_counter.sv ====
// Two 8-bit timer/event counter units with divider output and match interrupts.
// Assumes a one-cycle strobe register port, fc equal to i_sys_clk, fs and
// event inputs asynchronous pins.
//
// Overview of operation
// - Timer mode counts internal ticks; on equality raise match and restart from zero.
// - Event mode counts event pin falling edges; equality raises match and clears.
// - Compare value has no shadow; a write acts at once.
// - Divider mode toggles the output flip-flop on each match, clears, interrupts.
// - Divider pin always drives the inverse of the output flip-flop.
// - Preset bit loads the flip-flop; reset clears it to zero.
// - Stopping holds the pin level; preset rewrite after stop changes it.
// - Low speed allows only the slow tap for timers, only pin for events.
// - Cascaded operation takes its clock select from the lower unit.
// - Full speed offers fc/2048 or fs/8, fc/128, fc/32, fc/8; low only fs/8.
// - Mode code 000 is timer or event counter, 001 divider output.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
module dual_timer_counter (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [timer_pkg::ADDR_W-1:0] i_addr,
  input wire logic [timer_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [timer_pkg::DATA_W-1:0] o_rdata,
  input wire logic [timer_pkg::UNITS-1:0] i_event_in_pin,
  input wire logic i_fs_clk,
  output logic [timer_pkg::UNITS-1:0] o_divider_out_pin,
  output logic [timer_pkg::UNITS-1:0] o_match_irq,
  output logic o_irq
);
  localparam int unsigned N = timer_pkg::UNITS;
  localparam int unsigned W = timer_pkg::DATA_W;

  typedef struct packed {
    logic [N-1:0][W-1:0] ctrl;
    logic [N-1:0][W-1:0] cmp;
    logic [N-1:0][W-1:0] count;
    logic [N-1:0] ff;
    logic [N-1:0] run;
    logic [N-1:0] ev_last;
    logic [N-1:0] match;
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic [1:0] cfg;
    logic [W-1:0] rdata;
  } top_s;
  top_s q, d;

  logic [1:0] rst_sync_q;
  logic rstn;
  logic [N:0] pins_sync;
  logic [N-1:0] ev_level;
  logic low_speed;
  logic [N-1:0][W-1:0] ctrl_nxt;
  logic [N-1:0] ctrl_we;
  logic [N-1:0][2:0] mode;
  logic [N-1:0][2:0] sel;
  logic [N-1:0] start;
  logic [N-1:0] ev_mode;
  logic [N-1:0] src;
  logic [N-1:0] hit;
  logic [N-1:0][W-1:0] inc;
  logic cascade;

  tick_if ticks ();

  if (N != 2 || W != 8) begin : g_chk
    $error("dual_timer_counter serves two 8-bit units only");
  end

  function automatic logic [7:0] unit_off(input logic [7:0] base, input int unsigned u);
    return base + 8'(u) * timer_pkg::UNIT_STRIDE;
  endfunction

  // Reset is released through two flops so that every flop leaves reset together
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];

  sync_bits #(
    .W(N + 1)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(rstn),
    .i_async({i_fs_clk, i_event_in_pin}),
    .o_sync(pins_sync)
  );
  assign ev_level = pins_sync[N-1:0];
  assign low_speed = q.cfg[timer_pkg::CFG_LOW_SPEED_BIT];

  prescaler u_presc (
    .i_sys_clk(i_sys_clk),
    .i_rstn(rstn),
    .i_fs_level(pins_sync[N]),
    .i_tap_sel(q.cfg[timer_pkg::CFG_TAP_BIT]),
    .i_low_speed(low_speed),
    .ticks(ticks)
  );

  // Control seen by the counters is the value being written this cycle
  for (genvar u = 0; u < N; u++) begin : g_unit
    assign ctrl_we[u] = i_wr && (i_addr == unit_off(timer_pkg::OFF_CTRL3, u));
    assign ctrl_nxt[u] = ctrl_we[u] ? i_wdata : q.ctrl[u];
    assign mode[u] = ctrl_nxt[u][timer_pkg::CTRL_MODE_LSB +: 3];
    assign start[u] = ctrl_nxt[u][timer_pkg::CTRL_START_BIT];
    assign ev_mode[u] = (mode[u] == timer_pkg::MODE_TIMER_EVENT)
                        && (sel[u] == timer_pkg::SEL_PIN);
    assign inc[u] = q.count[u] + W'(1);
    assign hit[u] = (inc[u] == q.cmp[u]);
    // Only the four prescaler taps feed timer and divider; in low speed the
    // prescaler already silences all but the slow tap
    assign src[u] = ev_mode[u] ? (q.ev_last[u] & ~ev_level[u])
                  : ((mode[u] == timer_pkg::MODE_TIMER_EVENT
                      || mode[u] == timer_pkg::MODE_DIVIDER)
                     && sel[u] <= timer_pkg::SEL_FC_DIV8
                     && ticks.tick[sel[u]]);
    assign o_divider_out_pin[u] = ~q.ff[u];
  end

  // Upper unit in a 16-bit mode follows the lower unit's clock select
  assign cascade = mode[1][2];
  assign sel[0] = ctrl_nxt[0][timer_pkg::CTRL_SEL_LSB +: 3];
  assign sel[1] = cascade ? sel[0] : ctrl_nxt[1][timer_pkg::CTRL_SEL_LSB +: 3];

  always_comb begin
    d = q;
    d.ev_last = ev_level;
    d.match = '0;
    d.rdata = '0;
    for (int u = 0; u < N; u++) begin
      d.ctrl[u] = ctrl_nxt[u];
      if (i_wr && i_addr == unit_off(timer_pkg::OFF_CMP3, u)) begin
        d.cmp[u] = i_wdata;
      end
      d.run[u] = start[u];
      if (!start[u]) begin
        d.count[u] = '0;
      end else if (src[u]) begin
        if (hit[u]) begin
          d.count[u] = '0;
          d.match[u] = 1'b1;
          if (mode[u] == timer_pkg::MODE_DIVIDER) begin
            d.ff[u] = ~q.ff[u];
          end
        end else begin
          d.count[u] = inc[u];
        end
      end
      // A write that stops the timer leaves the flip-flop alone; the preset is
      // taken while stopped or together with the start
      if (ctrl_we[u] && !q.run[u]) begin
        d.ff[u] = i_wdata[timer_pkg::CTRL_PRESET_BIT];
      end
    end
    // Sticky status: a match in the clearing cycle survives
    d.status = q.status | q.match;
    if (i_wr && i_addr == timer_pkg::OFF_STATUS) begin
      d.status = (q.status & ~i_wdata[N-1:0]) | q.match;
    end
    if (i_wr && i_addr == timer_pkg::OFF_MASK) begin
      d.mask = i_wdata[N-1:0];
    end
    if (i_wr && i_addr == timer_pkg::OFF_CONFIG) begin
      d.cfg = i_wdata[1:0];
    end
    if (i_rd) begin
      for (int u = 0; u < N; u++) begin
        if (i_addr == unit_off(timer_pkg::OFF_CTRL3, u)) begin
          d.rdata = q.ctrl[u];
        end
        if (i_addr == unit_off(timer_pkg::OFF_CMP3, u)) begin
          d.rdata = q.cmp[u];
        end
        if (i_addr == unit_off(timer_pkg::OFF_COUNT3, u)) begin
          d.rdata = q.count[u];
        end
      end
      case (i_addr)
        timer_pkg::OFF_STATUS: d.rdata = W'(q.status);
        timer_pkg::OFF_MASK: d.rdata = W'(q.mask);
        timer_pkg::OFF_CONFIG: d.rdata = W'(q.cfg);
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      q.ctrl <= {N{timer_pkg::CTRL_RST}};
      q.cmp <= {N{timer_pkg::CMP_RST}};
      q.count <= '0;
      q.ff <= '0;
      q.run <= '0;
      q.ev_last <= '0;
      q.match <= '0;
      q.status <= '0;
      q.mask <= timer_pkg::MASK_RST;
      q.cfg <= timer_pkg::CFG_RST;
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_match_irq = q.match;
  assign o_irq = |(q.status & q.mask);

  // Checks below each cover one unit, unit 0 or unit 1, except the cascade check, which compares unit 1's select with unit 0's
  sequence s_hit0;
    start[0] && src[0] && hit[0];
  endsequence
  sequence s_cleared0;
    o_match_irq[0] && q.count[0] == 8'h00;
  endsequence

  property p_match_clear;
    @(posedge i_sys_clk) disable iff (!rstn)
      s_hit0 |=> s_cleared0;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("match did not clear unit 0");

  property p_event_count;
    @(posedge i_sys_clk) disable iff (!rstn)
      (start[1] && ev_mode[1] && src[1] && !hit[1])
        |=> q.count[1] == $past(q.count[1]) + 8'h01;
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("event edge not counted");

  property p_no_shadow;
    @(posedge i_sys_clk) disable iff (!rstn)
      (i_wr && i_addr == timer_pkg::OFF_CMP3) |=> q.cmp[0] == $past(i_wdata);
  endproperty
  a_no_shadow: assert property (p_no_shadow)
    else $error("compare write not immediate");

  property p_div_toggle;
    @(posedge i_sys_clk) disable iff (!rstn)
      (s_hit0 and (q.run[0] && mode[0] == timer_pkg::MODE_DIVIDER))
        |=> o_divider_out_pin[0] != $past(o_divider_out_pin[0]);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divider pin did not toggle on match");

  property p_pin_steady;
    @(posedge i_sys_clk) disable iff (!rstn)
      (!o_match_irq[1] && !$past(ctrl_we[1])) |-> $stable(o_divider_out_pin[1]);
  endproperty
  a_pin_steady: assert property (p_pin_steady)
    else $error("divider pin moved without match or preset");

  property p_preset;
    @(posedge i_sys_clk) disable iff (!rstn)
      (ctrl_we[0] && !q.run[0]) |=> q.ff[0] == $past(i_wdata[timer_pkg::CTRL_PRESET_BIT]);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset not loaded");

  property p_stop_hold;
    @(posedge i_sys_clk) disable iff (!rstn)
      (q.run[0] && !start[0]) |=> $stable(q.ff[0]) && q.count[0] == 8'h00;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop changed level or kept count");

  property p_low_speed_src;
    @(posedge i_sys_clk) disable iff (!rstn)
      (low_speed && !ev_mode[0] && sel[0] != timer_pkg::SEL_SLOW_TAP) |-> !src[0];
  endproperty
  a_low_speed_src: assert property (p_low_speed_src)
    else $error("fast source accepted in low speed");

  property p_cascade_sel;
    @(posedge i_sys_clk) disable iff (!rstn)
      cascade |-> sel[1] == ctrl_nxt[0][timer_pkg::CTRL_SEL_LSB +: 3];
  endproperty
  a_cascade_sel: assert property (p_cascade_sel)
    else $error("cascade not on lower select");

  property p_irq_level;
    @(posedge i_sys_clk) disable iff (!rstn)
      (o_match_irq[0] && q.mask[0]) |=> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked match did not raise interrupt");

  sequence s_hit1;
    start[1] && ev_mode[1] && src[1] && hit[1];
  endsequence
  sequence s_cleared1;
    o_match_irq[1] && q.count[1] == 8'h00;
  endsequence

  property p_event_clear;
    @(posedge i_sys_clk) disable iff (!rstn)
      s_hit1 |=> s_cleared1;
  endproperty
  a_event_clear: assert property (p_event_clear)
    else $error("event match did not clear unit 1");

  property p_other_mode_idle;
    @(posedge i_sys_clk) disable iff (!rstn)
      (mode[1] != timer_pkg::MODE_TIMER_EVENT && mode[1] != timer_pkg::MODE_DIVIDER)
        |-> !src[1];
  endproperty
  a_other_mode_idle: assert property (p_other_mode_idle)
    else $error("unit 1 counted in an unsupported mode");

  property p_count_hold;
    @(posedge i_sys_clk) disable iff (!rstn)
      (start[0] && !src[0]) |=> q.count[0] == $past(q.count[0]);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("unit 0 count moved without a tick");

  property p_stopped_idle;
    @(posedge i_sys_clk) disable iff (!rstn)
      !start[1] |=> q.count[1] == 8'h00 && !o_match_irq[1];
  endproperty
  a_stopped_idle: assert property (p_stopped_idle)
    else $error("stopped unit 1 counted or matched");

  property p_status_set;
    @(posedge i_sys_clk) disable iff (!rstn)
      o_match_irq[0] |=> q.status[0];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("match did not set status bit");

  property p_timer_ff_hold;
    @(posedge i_sys_clk) disable iff (!rstn)
      (mode[0] == timer_pkg::MODE_TIMER_EVENT && !(ctrl_we[0] && !q.run[0]))
        |=> q.ff[0] == $past(q.ff[0]);
  endproperty
  a_timer_ff_hold: assert property (p_timer_ff_hold)
    else $error("flip-flop moved in timer mode");
endmodule

// ==== sim/pin_partner.sv ====
// Far side of the timer: event pulse source and pulled-up divider pads.
// Assumes it shares i_sys_clk with the timer; the port latch comes from the bench.
`timescale 1ns/100ps
module pin_partner (
  input wire logic i_sys_clk,
  input wire logic [timer_pkg::UNITS-1:0] i_port_latch,
  input wire logic [timer_pkg::UNITS-1:0] i_divider_out_pin,
  output logic [timer_pkg::UNITS-1:0] o_event_in_pin,
  output logic [timer_pkg::UNITS-1:0] o_pad
);
  // Pads are pulled up, so a latch at zero keeps the timer off the pad
  assign o_pad = ~i_port_latch | i_divider_out_pin;

  initial o_event_in_pin = 2'h3;

  // One falling edge; each phase lasts hold clocks, never fewer than two
  task automatic pulse(input int unit, input int hold);
    repeat (hold) @(posedge i_sys_clk);
    o_event_in_pin[unit] <= 1'b0;
    repeat (hold) @(posedge i_sys_clk);
    o_event_in_pin[unit] <= 1'b1;
  endtask
endmodule

// ==== sim/dual_timer_counter_tb_top.sv ====
// Self-checking bench for the dual timer: register tasks and mode scenarios.
// Assumes the register map and control layout of timer_pkg.
`timescale 1ns/100ps
module dual_timer_counter_tb_top;
  logic i_sys_clk, i_rstn, i_wr, i_rd, i_fs_clk, o_irq;
  logic [7:0] i_addr, i_wdata, o_rdata, rd_v;
  logic [1:0] ev_pin, div_pin, match, pad, latch;
  int error_cnt, cmp_count, cyc, s;
  int mcnt[2], last_t[2], prev_t[2];
  localparam logic [7:0] STR = timer_pkg::UNIT_STRIDE;
  localparam logic [2:0] SELS[4] = '{3'h0, 3'h1, 3'h2, 3'h3};
  localparam int DIVS[4] = '{2048, 128, 32, 8};
  localparam logic [2:0] TMR = timer_pkg::MODE_TIMER_EVENT;
  localparam logic [2:0] DIV = timer_pkg::MODE_DIVIDER;
  localparam logic [2:0] CASC = timer_pkg::MODE_CASC_TIMER;
  localparam logic [2:0] FC8 = timer_pkg::SEL_FC_DIV8;

  dual_timer_counter i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_in_pin(ev_pin),
    .i_fs_clk(i_fs_clk), .o_divider_out_pin(div_pin), .o_match_irq(match), .o_irq(o_irq));
  pin_partner i_pp (.i_sys_clk(i_sys_clk), .i_port_latch(latch), .i_divider_out_pin(div_pin),
    .o_event_in_pin(ev_pin), .o_pad(pad));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // fs runs at 8 system clocks, off the rising system edges
  initial begin
    i_fs_clk = 1'b0;
    forever #40 i_fs_clk = ~i_fs_clk;
  end

  // Match pulses last one cycle, so the cycle of each is recorded here
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    for (int u = 0; u < 2; u++) begin
      if (match[u] === 1'b1) begin
        mcnt[u] <= mcnt[u] + 1;
        prev_t[u] <= last_t[u];
        last_t[u] <= cyc;
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] m, input logic [2:0] sl, input logic st,
                                     input logic pr);
    return {pr, sl, st, m};
  endfunction

  // Bounded wait for k more matches of unit u
  task automatic wait_m(input int u, input int k, input int lim);
    int st;
    st = mcnt[u];
    for (int i = 0; i < lim && mcnt[u] < st + k; i++) begin
      @(posedge i_sys_clk);
      #1;
    end
    // A stale period from an earlier scenario must not pass for a fresh one
    if (mcnt[u] < st + k) begin
      error_cnt++;
      $display("ERROR matches of unit %0d expected %0d seen %0d", u, k, mcnt[u] - st);
    end
  endtask

  // First match may follow a partial period, so the last two are compared
  task automatic per_chk(input int u, input int e, input int lim, input string n);
    wait_m(u, 3, lim);
    chk(n, e, last_t[u] - prev_t[u]);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The scenarios need about 16k cycles; 40k leaves room without hiding a hang
  initial begin
    #400_000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    latch = 2'h3;
    repeat (8) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("reset divider pins", 2'h3, div_pin);
    chk("reset irq", 1'b0, o_irq);
    rd(timer_pkg::OFF_CMP3);
    chk("cmp3 reset", timer_pkg::CMP_RST, rd_v);
    rd(8'hFC);
    chk("unmapped read", 8'h00, rd_v);
    // Timer periods over every full-speed tap, preset kept at zero
    wr(timer_pkg::OFF_CMP3, 8'h02);
    rd(timer_pkg::OFF_CMP3);
    chk("cmp3 written", 8'h02, rd_v);
    for (int i = 0; i < 4; i++) begin
      wr(timer_pkg::OFF_CTRL3, ctl(TMR, SELS[i], 1'b1, 1'b0));
      per_chk(0, 2 * DIVS[i], 13000, "timer period");
      wr(timer_pkg::OFF_CTRL3, ctl(TMR, SELS[i], 1'b0, 1'b0));
    end
    rd(timer_pkg::OFF_COUNT3);
    chk("count3 after stop", 8'h00, rd_v);
    wr(timer_pkg::OFF_CONFIG, 8'h02);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h0, 1'b1, 1'b0));
    per_chk(0, 128, 1000, "fs tap period");
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h0, 1'b0, 1'b0));
    // Low speed: only the slow tap counts
    wr(timer_pkg::OFF_CONFIG, 8'h01);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h1, 1'b1, 1'b0));
    s = mcnt[0];
    repeat (600) @(posedge i_sys_clk);
    chk("low speed fc tap matches", s, mcnt[0]);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h1, 1'b0, 1'b0));
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h0, 1'b1, 1'b0));
    per_chk(0, 128, 1000, "low speed period");
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, 3'h0, 1'b0, 1'b0));
    wr(timer_pkg::OFF_CONFIG, 8'h00);
    // Interrupt raised, cleared, then masked
    wr(timer_pkg::OFF_MASK, 8'h01);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, FC8, 1'b1, 1'b0));
    wait_m(0, 1, 100);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, FC8, 1'b0, 1'b0));
    chk("irq unmasked", 1'b1, o_irq);
    rd(timer_pkg::OFF_STATUS);
    chk("status", 8'h01, rd_v);
    wr(timer_pkg::OFF_STATUS, 8'h01);
    #1 chk("irq cleared", 1'b0, o_irq);
    wr(timer_pkg::OFF_MASK, 8'h00);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, FC8, 1'b1, 1'b0));
    wait_m(0, 1, 100);
    wr(timer_pkg::OFF_CTRL3, ctl(TMR, FC8, 1'b0, 1'b0));
    chk("irq masked", 1'b0, o_irq);
    rd(timer_pkg::OFF_STATUS);
    chk("status masked", 8'h01, rd_v);
    wr(timer_pkg::OFF_STATUS, 8'h01);
    // Event counting on unit4, slow then prompt pulses
    wr(timer_pkg::OFF_CMP3 + STR, 8'h02);
    wr(timer_pkg::OFF_CTRL3 + STR, ctl(TMR, timer_pkg::SEL_PIN, 1'b1, 1'b0));
    i_pp.pulse(1, 6);
    repeat (6) @(posedge i_sys_clk);
    rd(timer_pkg::OFF_COUNT3 + STR);
    chk("count4 one edge", 8'h01, rd_v);
    s = mcnt[1];
    i_pp.pulse(1, 2);
    repeat (6) @(posedge i_sys_clk);
    chk("event match", s + 1, mcnt[1]);
    rd(timer_pkg::OFF_COUNT3 + STR);
    chk("count4 cleared", 8'h00, rd_v);
    // Upper unit in a 16-bit mode takes unit3's select and does not count alone
    wr(timer_pkg::OFF_CTRL3 + STR, ctl(TMR, timer_pkg::SEL_PIN, 1'b0, 1'b0));
    wr(timer_pkg::OFF_CTRL3 + STR, ctl(CASC, 3'h5, 1'b1, 1'b0));
    s = mcnt[1];
    repeat (40) @(posedge i_sys_clk);
    chk("cascade upper matches", s, mcnt[1]);
    rd(timer_pkg::OFF_COUNT3 + STR);
    chk("cascade upper count", 8'h00, rd_v);
    wr(timer_pkg::OFF_CTRL3 + STR, ctl(CASC, 3'h5, 1'b0, 1'b0));
    // Divider output on unit3
    wr(timer_pkg::OFF_CTRL3, ctl(DIV, FC8, 1'b0, 1'b1));
    #1 chk("preset pin", 1'b0, div_pin[0]);
    wr(timer_pkg::OFF_CTRL3, ctl(DIV, FC8, 1'b1, 1'b1));
    per_chk(0, 16, 500, "divider half period");
    chk("divider pin", 1'b1, div_pin[0]);
    wr(timer_pkg::OFF_CTRL3, ctl(DIV, FC8, 1'b0, 1'b1));
    s = mcnt[0];
    repeat (40) @(posedge i_sys_clk);
    #1 chk("held pin", 1'b1, div_pin[0]);
    chk("no match stopped", s, mcnt[0]);
    wr(timer_pkg::OFF_CTRL3, ctl(DIV, FC8, 1'b0, 1'b1));
    #1 chk("preset after stop", 1'b0, pad[0]);
    latch <= 2'h2;
    #1 chk("pad latch off", 1'b1, pad[0]);
    wrap_up();
  end
endmodule
